// [design/jtt_pkg.sv]
// package: tap states, instruction codes, chain sizes and controls
`default_nettype none
package jtt_pkg;

   localparam int IR_W  = 4;
   localparam int ID_W  = 32;
   localparam int BSR_W = 8;
   localparam int USR_W = 8;

   localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] IR_INTEST = 4'h1;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
   localparam logic [IR_W-1:0] IR_ABORT  = 4'h8;
   localparam logic [IR_W-1:0] IR_DPACC  = 4'hA;
   localparam logic [IR_W-1:0] IR_APACC  = 4'hB;
   localparam logic [IR_W-1:0] IR_USER   = 4'hC;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'hE;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

   // fixed pattern loaded into the instruction chain on capture
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   // identity word, value is arbitrary
   localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_1235;
   localparam logic BYP_CAPTURE = 1'h0;
   localparam logic [BSR_W-1:0] BSR_RESET = 8'h00;
   localparam logic [USR_W-1:0] USR_RESET = 8'h00;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } jtt_state_t;

   typedef enum logic [2:0] {
      CH_BYPASS, CH_IDCODE, CH_BOUND, CH_USER, CH_CORE
   } jtt_chain_t;

   typedef struct packed {
      logic tlr;
      logic cap_ir;
      logic shift_ir;
      logic upd_ir;
      logic cap_dr;
      logic shift_dr;
      logic upd_dr;
   } jtt_ctl_t;

   // instruction to data chain; unknown codes and hold-mode tests use bypass
   function automatic jtt_chain_t jtt_decode(input logic [IR_W-1:0] ir);
      case (ir)
         IR_IDCODE:                     return CH_IDCODE;
         IR_SAMPLE:                     return CH_BOUND;
         IR_USER:                       return CH_USER;
         IR_ABORT, IR_DPACC, IR_APACC:  return CH_CORE;
         default:                       return CH_BYPASS;
      endcase
   endfunction : jtt_decode

endpackage : jtt_pkg
`default_nettype wire

// [design/jtt_tap_fsm.sv]
// tap controller state machine on the test clock
`default_nettype none
module jtt_tap_fsm (
   input  wire logic                i_tck,
   input  wire logic                i_tap_rst_b,
   input  wire logic                i_tms,
   output var  jtt_pkg::jtt_state_t o_state,
   output var  jtt_pkg::jtt_ctl_t   o_ctl
);
   import jtt_pkg::*;

   jtt_state_t state_q;
   jtt_state_t state_d;

   always_comb begin
      case (state_q)
         ST_TLR:    state_d = i_tms ? ST_TLR    : ST_RTI;
         ST_RTI:    state_d = i_tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  state_d = i_tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = i_tms ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  state_d = i_tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_d = i_tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = i_tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_d = i_tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  state_d = i_tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = i_tms ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  state_d = i_tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_d = i_tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = i_tms ? ST_SEL_DR : ST_RTI;
         default:   state_d = ST_TLR;
      endcase
   end

   // tms taken on the rising edge only; a stopped clock holds the state
   always_ff @(posedge i_tck or negedge i_tap_rst_b) begin
      if (!i_tap_rst_b) begin
         state_q <= ST_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      o_state        = state_q;
      o_ctl.tlr      = (state_q == ST_TLR);
      o_ctl.cap_ir   = (state_q == ST_CAP_IR);
      o_ctl.shift_ir = (state_q == ST_SH_IR);
      o_ctl.upd_ir   = (state_q == ST_UPD_IR);
      o_ctl.cap_dr   = (state_q == ST_CAP_DR);
      o_ctl.shift_dr = (state_q == ST_SH_DR);
      o_ctl.upd_dr   = (state_q == ST_UPD_DR);
   end

endmodule : jtt_tap_fsm
`default_nettype wire

// [design/jtt_evt_sync.sv]
// toggle-to-pulse crossing into the system clock
`default_nettype none
module jtt_evt_sync (
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   input  wire logic i_toggle,
   output var  logic o_pulse
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         meta_q <= 1'h0;
         sync_q <= 1'h0;
         last_q <= 1'h0;
      end else begin
         meta_q <= i_toggle;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign o_pulse = sync_q ^ last_q;

endmodule : jtt_evt_sync
`default_nettype wire

// [design/jtt_tap_top.sv]
// test access port with instruction, bypass, identity, boundary and user chains
`default_nettype none
module jtt_tap_top (
   input  wire logic                        i_mclk,
   input  wire logic                        i_rst_b,
   input  wire logic                        i_tck,
   input  wire logic                        i_trst_b,
   input  wire logic                        i_tms,
   input  wire logic                        i_tdi,
   input  wire logic                        i_core_tdo,
   input  wire logic [jtt_pkg::BSR_W-1:0]   i_pins,
   output var  logic                        o_tdo,
   output var  logic                        o_tdo_oe,
   output var  logic                        o_core_sel,
   output var  logic [jtt_pkg::BSR_W-1:0]   o_bsr_data,
   output var  logic                        o_bsr_drive,
   output var  logic                        o_int_test,
   output var  logic [jtt_pkg::USR_W-1:0]   o_user_data,
   output var  logic                        o_user_valid
);
   import jtt_pkg::*;

   // system clock side: power-on reset source

   logic                 por_b_q;
   logic                 tap_rst_b;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         por_b_q <= 1'h0;
      end else begin
         por_b_q <= 1'h1;
      end
   end

   // both sources are glitch free: a pin and a flop output
   // release is not aligned to the test clock, so the host keeps it still then
   assign tap_rst_b = i_trst_b & por_b_q;

   // controller

   jtt_state_t           state;
   jtt_ctl_t             ctl;

   jtt_tap_fsm u_fsm (
      .i_tck       (i_tck),
      .i_tap_rst_b (tap_rst_b),
      .i_tms       (i_tms),
      .o_state     (state),
      .o_ctl       (ctl)
   );

   // pin sampling for the boundary chain

   logic [BSR_W-1:0]     pins_meta_q;
   logic [BSR_W-1:0]     pins_sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < BSR_W; gi++) begin : g_pin_sync
         always_ff @(posedge i_tck or negedge tap_rst_b) begin
            if (!tap_rst_b) begin
               pins_meta_q[gi] <= 1'h0;
               pins_sync_q[gi] <= 1'h0;
            end else begin
               pins_meta_q[gi] <= i_pins[gi];
               pins_sync_q[gi] <= pins_meta_q[gi];
            end
         end
      end
   endgenerate

   // instruction chain and register

   logic [IR_W-1:0]      ir_sr_q;
   logic [IR_W-1:0]      ir_q;
   logic [IR_W-1:0]      ir_d;
   jtt_chain_t           sel;
   logic                 tlr_entry;

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         ir_sr_q <= IR_CAPTURE;
      end else if (ctl.cap_ir) begin
         ir_sr_q <= IR_CAPTURE;
      end else if (ctl.shift_ir) begin
         ir_sr_q <= {i_tdi, ir_sr_q[IR_W-1:1]};
      end
   end

   // the edge that enters test-logic-reset already loads the default
   assign tlr_entry = (state == ST_SEL_IR) && i_tms;

   always_comb begin
      ir_d = ir_q;
      if (ctl.tlr || tlr_entry) begin
         ir_d = IR_IDCODE;
      end else if (ctl.upd_ir) begin
         ir_d = ir_sr_q;
      end
   end

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         ir_q <= IR_IDCODE;
      end else begin
         ir_q <= ir_d;
      end
   end

   // held instruction picks the data chain
   assign sel = jtt_decode(ir_q);

   // bypass chain

   logic                 byp_q;

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         byp_q <= BYP_CAPTURE;
      end else if (sel == CH_BYPASS) begin
         if (ctl.cap_dr) begin
            byp_q <= BYP_CAPTURE;
         end else if (ctl.shift_dr) begin
            byp_q <= i_tdi;
         end
      end
   end

   // identity chain

   logic [ID_W-1:0]      id_sr_q;

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         id_sr_q <= ID_VALUE;
      end else if (sel == CH_IDCODE) begin
         if (ctl.cap_dr) begin
            id_sr_q <= ID_VALUE;
         end else if (ctl.shift_dr) begin
            id_sr_q <= {i_tdi, id_sr_q[ID_W-1:1]};
         end
      end
   end

   // boundary chain, sample/preload

   logic [BSR_W-1:0]     bsr_sr_q;
   logic [BSR_W-1:0]     bsr_upd_q;

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         bsr_sr_q <= BSR_RESET;
      end else if (sel == CH_BOUND) begin
         if (ctl.cap_dr) begin
            bsr_sr_q <= pins_sync_q;
         end else if (ctl.shift_dr) begin
            bsr_sr_q <= {i_tdi, bsr_sr_q[BSR_W-1:1]};
         end
      end
   end

   // parallel register keeps its value through shifting
   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         bsr_upd_q <= BSR_RESET;
      end else if (sel == CH_BOUND && ctl.upd_dr) begin
         bsr_upd_q <= bsr_sr_q;
      end
   end

   // user chain, update is passed to the system side

   logic [USR_W-1:0]     usr_sr_q;
   logic [USR_W-1:0]     usr_upd_q;
   logic                 usr_tgl_q;

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         usr_sr_q <= USR_RESET;
      end else if (sel == CH_USER) begin
         if (ctl.cap_dr) begin
            usr_sr_q <= usr_upd_q;
         end else if (ctl.shift_dr) begin
            usr_sr_q <= {i_tdi, usr_sr_q[USR_W-1:1]};
         end
      end
   end

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         usr_upd_q <= USR_RESET;
      end else if (sel == CH_USER && ctl.upd_dr) begin
         usr_upd_q <= usr_sr_q;
      end
   end

   // toggles on the same edge that loads the word; crossing reads the word later
   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         usr_tgl_q <= 1'h0;
      end else if (sel == CH_USER && ctl.upd_dr) begin
         usr_tgl_q <= ~usr_tgl_q;
      end
   end

   // instruction-driven mode outputs

   logic                 core_sel_q;
   logic                 bsr_drive_q;
   logic                 int_test_q;

   // taken from the next instruction so modes follow the update edge
   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         core_sel_q <= 1'h0;
      end else begin
         core_sel_q <= (jtt_decode(ir_d) == CH_CORE);
      end
   end

   // only the hold-mode IR_EXTEST drives the last preloaded boundary data; the boundary chain holds while bypass shifts
   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         bsr_drive_q <= 1'h0;
      end else begin
         bsr_drive_q <= (ir_d == IR_EXTEST);
      end
   end

   always_ff @(posedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         int_test_q <= 1'h0;
      end else begin
         int_test_q <= (ir_d == IR_INTEST);
      end
   end

   assign o_core_sel  = core_sel_q;
   assign o_bsr_drive = bsr_drive_q;
   assign o_int_test  = int_test_q;
   assign o_bsr_data  = bsr_upd_q;

   // serial output, falling edge

   logic                 tdo_bit;
   logic                 tdo_q;
   logic                 tdo_oe_q;

   always_comb begin
      if (ctl.shift_ir) begin
         tdo_bit = ir_sr_q[0];
      end else begin
         case (sel)
            CH_IDCODE: tdo_bit = id_sr_q[0];
            CH_BOUND:  tdo_bit = bsr_sr_q[0];
            CH_USER:   tdo_bit = usr_sr_q[0];
            CH_CORE:   tdo_bit = i_core_tdo;
            default:   tdo_bit = byp_q;
         endcase
      end
   end

   // launched on the falling edge for the next device in a daisy chain
   always_ff @(negedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         tdo_q <= 1'h0;
      end else begin
         tdo_q <= tdo_bit;
      end
   end

   // drive only through the shift states, the pin floats otherwise
   always_ff @(negedge i_tck or negedge tap_rst_b) begin
      if (!tap_rst_b) begin
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_oe_q <= ctl.shift_ir | ctl.shift_dr;
      end
   end

   assign o_tdo    = tdo_q;
   assign o_tdo_oe = tdo_oe_q;

   // system clock side: user word delivery

   logic                 usr_evt;
   logic [USR_W-1:0]     user_data_q;
   logic                 user_valid_q;

   jtt_evt_sync u_usr_sync (
      .i_clk    (i_mclk),
      .i_rst_b  (i_rst_b),
      .i_toggle (usr_tgl_q),
      .o_pulse  (usr_evt)
   );

   // word is stable: it changes only at an update, which the toggle follows, or at a tap reset, which also clears the toggle
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         user_data_q <= USR_RESET;
      end else if (usr_evt) begin
         user_data_q <= usr_upd_q;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         user_valid_q <= 1'h0;
      end else begin
         user_valid_q <= usr_evt;
      end
   end

   assign o_user_data  = user_data_q;
   assign o_user_valid = user_valid_q;

endmodule : jtt_tap_top
`default_nettype wire

// [testbench/jtt_tap_properties.sv]
// concurrent checks on the test access port pins and user word outputs
`default_nettype none
module jtt_tap_checker (
   input wire logic                    i_mclk,
   input wire logic                    i_rst_b,
   input wire logic                    i_tck,
   input wire logic                    i_trst_b,
   input wire logic                    i_tms,
   input wire logic                    i_tdi,
   input wire logic                    i_core_tdo,
   input wire logic [jtt_pkg::BSR_W-1:0] i_pins,
   input wire logic                    o_tdo,
   input wire logic                    o_tdo_oe,
   input wire logic                    o_core_sel,
   input wire logic [jtt_pkg::BSR_W-1:0] o_bsr_data,
   input wire logic                    o_bsr_drive,
   input wire logic                    o_int_test,
   input wire logic [jtt_pkg::USR_W-1:0] o_user_data,
   input wire logic                    o_user_valid
);
   property p_tdo_fall;
      @(posedge i_mclk) disable iff (!i_rst_b || !i_trst_b)
      (i_tck && $past(i_tck)) |-> ($stable(o_tdo) && $stable(o_tdo_oe));
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved with clock high");
   property p_oe_rise;
      @(posedge i_tck) disable iff (!i_rst_b || !i_trst_b)
      $rose(o_tdo_oe) |-> !$past(i_tms);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("drive began off a shift entry");
   property p_oe_fall;
      @(posedge i_tck) disable iff (!i_rst_b || !i_trst_b)
      $fell(o_tdo_oe) |-> $past(i_tms);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("drive ended inside shift");
   property p_tms_reset;
      @(posedge i_tck) disable iff (!i_rst_b || !i_trst_b)
      i_tms [*5] |=> (!o_core_sel && !o_bsr_drive && !o_int_test);
   endproperty
   a_tms_reset: assert property (p_tms_reset) else $error("modes kept after five highs");
   property p_trst;
      @(posedge i_mclk) disable iff (!i_rst_b)
      !i_trst_b |-> (!o_tdo_oe && !o_core_sel && !o_bsr_drive && !o_int_test && o_bsr_data == '0);
   endproperty
   a_trst: assert property (p_trst) else $error("outputs active in test reset");
   property p_hold;
      @(posedge i_mclk) disable iff (!i_rst_b || !i_trst_b)
      $stable(i_tck) |-> $stable({o_core_sel, o_bsr_drive, o_int_test, o_bsr_data, o_tdo_oe});
   endproperty
   a_hold: assert property (p_hold) else $error("state moved with clock stopped");
   property p_bsr_shift;
      @(posedge i_tck) disable iff (!i_rst_b || !i_trst_b)
      (o_tdo_oe && $past(o_tdo_oe)) |-> $stable(o_bsr_data);
   endproperty
   a_bsr_shift: assert property (p_bsr_shift) else $error("boundary word moved in shift");
   property p_user_pulse;
      @(posedge i_mclk) disable iff (!i_rst_b)
      o_user_valid |=> !o_user_valid;
   endproperty
   a_user_pulse: assert property (p_user_pulse) else $error("user valid too long");
   property p_user_data;
      @(posedge i_mclk) disable iff (!i_rst_b)
      $changed(o_user_data) |-> o_user_valid;
   endproperty
   a_user_data: assert property (p_user_data) else $error("user word moved unflagged");
   c_user: cover property (@(posedge i_mclk) o_user_valid);
   c_core: cover property (@(posedge i_tck) o_core_sel && o_tdo_oe);
   c_tms5: cover property (@(posedge i_tck) i_tms [*5]);
endmodule : jtt_tap_checker

bind jtt_tap_top jtt_tap_checker i_chk (.i_mclk, .i_rst_b, .i_tck, .i_trst_b, .i_tms, .i_tdi,
   .i_core_tdo, .i_pins, .o_tdo, .o_tdo_oe, .o_core_sel, .o_bsr_data, .o_bsr_drive,
   .o_int_test, .o_user_data, .o_user_valid);
`default_nettype wire

// [testbench/jtt_host_model.sv]
// test host model: makes the test clock and drives mode select and data in
`default_nettype none
module jtt_host_model (
   output var  logic o_tck,
   output var  logic o_tms,
   output var  logic o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic line;
   assign line = i_tdo_oe ? i_tdo : 1'b1; // released line pulled high
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // one test clock cycle, pins move while the clock is low
   task automatic tick(input logic t, input logic d, output logic o);
      o_tms = t;
      o_tdi = d;
      #80;
      o = line;
      o_tck = 1'b1;
      #80;
      o_tck = 1'b0;
   endtask : tick
   task automatic to_idle;
      logic o;
      #7;
      repeat (5) tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
   endtask : to_idle
   // from idle: capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic o;
      #7;
      dout = '0;
      tick(1'b1, 1'b1, o);
      if (ir) tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
   endtask : scan
endmodule : jtt_host_model
`default_nettype wire

// [testbench/jtt_tap_shift_chains_bench.sv]
// bench for the test access port driven through the host model
`default_nettype none
module jtt_tap_shift_chains_bench import jtt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic             mclk, rst_b, trst_b, core_tdo, o;
   logic             tck, tms, tdi, tdo, tdo_oe, core_sel, bsr_drive, int_test, user_valid;
   logic [BSR_W-1:0] pins, bsr_data;
   logic [USR_W-1:0] user_data, last_word;
   logic [31:0]      d;
   int               err_total = 0;
   int               num_checks = 0;
   int               n_words = 0;

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   jtt_tap_top i_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_tck(tck), .i_trst_b(trst_b),
      .i_tms(tms), .i_tdi(tdi), .i_core_tdo(core_tdo), .i_pins(pins), .o_tdo(tdo),
      .o_tdo_oe(tdo_oe), .o_core_sel(core_sel), .o_bsr_data(bsr_data),
      .o_bsr_drive(bsr_drive), .o_int_test(int_test), .o_user_data(user_data),
      .o_user_valid(user_valid));
   jtt_host_model i_host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
      .i_tdo_oe(tdo_oe));

   always @(posedge mclk) begin
      if (user_valid === 1'b1) begin
         n_words++;
         last_word = user_data;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ir(input logic [3:0] c);
      i_host.scan(1'b1, 4, {28'h0, c}, d);
   endtask : ir
   task automatic dr(input int n, input logic [31:0] din);
      i_host.scan(1'b0, n, din, d);
   endtask : dr

   task automatic t_idcode;
      chk(tdo_oe, 1'b0);
      dr(32, 32'h0);
      chk(d, ID_VALUE);
      ir(IR_BYPASS);
      chk(d[3:0], IR_CAPTURE);
      $display("test idcode done");
   endtask : t_idcode
   task automatic t_sample;
      @(posedge mclk) pins <= 8'hA5;
      ir(IR_SAMPLE);
      dr(8, 32'h3C);
      chk(d[7:0], 8'hA5);
      chk(bsr_data, 8'h3C);
      $display("test sample done");
   endtask : t_sample
   task automatic t_bypass;
      logic [3:0] c [10] = '{IR_BYPASS, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hD,
                             IR_EXTEST, IR_INTEST};
      for (int i = 0; i < 10; i++) begin
         ir(c[i]);
         chk({bsr_drive, int_test}, {c[i] == IR_EXTEST, c[i] == IR_INTEST});
         dr(8, 32'hB6);
         chk(d[7:0], 8'h6C);
         chk(bsr_data, 8'h3C);
      end
      $display("test bypass done");
   endtask : t_bypass
   task automatic t_user;
      int n;
      n = n_words;
      ir(IR_USER);
      dr(8, 32'h5A);
      repeat (8) @(posedge mclk);
      chk(n_words - n, 1);
      chk(last_word, 8'h5A);
      repeat (50) @(posedge mclk);
      dr(8, 32'hC3);
      chk(d[7:0], 8'h5A);
      $display("test user done");
   endtask : t_user
   task automatic t_core;
      logic [3:0] c [3] = '{IR_ABORT, IR_DPACC, IR_APACC};
      for (int i = 0; i < 3; i++) begin
         ir(c[i]);
         chk(core_sel, 1'b1);
         @(posedge mclk) core_tdo <= (i != 1);
         dr(4, 32'h0);
         chk(d[3:0], (i != 1) ? 4'hF : 4'h0);
      end
      ir(IR_IDCODE);
      chk(d[3:0], IR_CAPTURE);
      chk(core_sel, 1'b0);
      $display("test core done");
   endtask : t_core
   task automatic t_tms_reset;
      ir(IR_EXTEST);
      chk(bsr_drive, 1'b1);
      i_host.tick(1'b1, 1'b1, o);
      repeat (3) i_host.tick(1'b0, 1'b1, o);
      repeat (5) i_host.tick(1'b1, 1'b0, o);
      chk(bsr_drive, 1'b0);
      i_host.tick(1'b0, 1'b1, o);
      dr(32, 32'h0);
      chk(d, ID_VALUE);
      $display("test mode reset done");
   endtask : t_tms_reset
   task automatic t_trst;
      ir(IR_ABORT);
      @(posedge mclk) trst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({core_sel, tdo_oe}, 2'b00);
      repeat (3) i_host.tick(1'b0, 1'b1, o);
      chk(core_sel, 1'b0);
      @(posedge mclk) trst_b <= 1'b1;
      @(posedge mclk);
      i_host.tick(1'b0, 1'b1, o);
      dr(32, 32'h0);
      chk(d, ID_VALUE);
      $display("test test reset done");
   endtask : t_trst
   task automatic t_por;
      ir(IR_EXTEST);
      @(posedge mclk) rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({bsr_drive, user_data}, 9'h0);
      @(posedge mclk) rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      i_host.tick(1'b0, 1'b1, o);
      dr(32, 32'h0);
      chk(d, ID_VALUE);
      $display("test power reset done");
   endtask : t_por

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #1000000;
      err_total++;
      $display("watchdog expired");
      report_and_stop;
   end
   initial begin
      rst_b = 1'b0;
      trst_b = 1'b1;
      core_tdo = 1'b0;
      pins = '0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      i_host.to_idle;
      t_idcode;
      t_sample;
      t_bypass;
      t_user;
      t_core;
      t_tms_reset;
      t_trst;
      t_por;
      report_and_stop;
   end
endmodule : jtt_tap_shift_chains_bench
`default_nettype wire
